// *** design/kms_keypad_scanner.v ***
// matrix keypad scanner with debounce, column ordering and apb registers
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "kms_map.vh"

// ======================================================================
// What this block does
// - five low column drives, six row senses
// - automatic scanning off until enable set
// - timing from 1 kHz tick, gated enable
// - idle: all columns low, await row low
// - debounce press; false press returns idle
// - debounce 4 to 256 ms, 4 ms steps
// - one column low, rows checked per interval
// - scan every configured column, fixed interval
// - column order from order registers; rows fixed
// - exactly one closed switch is valid
// - valid key stores patterns, raises interrupt
// - patterns change only on valid key
// - scanning never waits for firmware
// - await release, debounce, then idle
// - disabled: columns follow column register
// - column register bit-maps column pins
// - row register bit-maps row pins
// - keypad size limits rows and columns
// - debounce value times 4, zero 256
// - detect flag clears on read
// - bypass row fall sets flag, tick-free
module kms_keypad_scanner #(
	parameter TICK_CYC = `KMS_TICK_CYC
) (
	input  wire        CORE_CLK_IN,
	input  wire        RST_IN,
	input  wire        TICK_ENABLE_IN,
	input  wire [5:0]  ROW_IN,
	output reg  [4:0]  COL_N_OUT,
	output wire        KEY_IRQ_OUT,
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [11:0] PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output reg  [31:0] PRDATA_OUT,
	output wire        PREADY_OUT,
	output wire        PSLVERR_OUT
);

	// ==================================================================
	// state codes
	localparam [5:0] S_OFF    = 6'h01;
	localparam [5:0] S_IDLE   = 6'h02;
	localparam [5:0] S_DBPRS  = 6'h04;
	localparam [5:0] S_SCAN   = 6'h08;
	localparam [5:0] S_WREL   = 6'h10;
	localparam [5:0] S_DBREL  = 6'h20;

	// ==================================================================
	// word indices of the mapped registers
	localparam [9:0] W_COL    = {2'b00, `KMS_IDX_COL};
	localparam [9:0] W_ROW    = {2'b00, `KMS_IDX_ROW};
	localparam [9:0] W_SCAN   = {2'b00, `KMS_IDX_SCAN};
	localparam [9:0] W_CTRL   = {2'b00, `KMS_IDX_CTRL};
	localparam [9:0] W_ORD_LO = {2'b00, `KMS_IDX_ORDER_LO};
	localparam [9:0] W_ORD_HI = {2'b00, `KMS_IDX_ORDER_HI};
	localparam [9:0] W_SIZE   = {2'b00, `KMS_IDX_SIZE};

	// ==================================================================
	// declarations
	reg  [4:0]  col_ff;
	reg  [5:0]  row_ff;
	reg  [7:0]  scan_ff;
	reg  [7:0]  ord_lo_ff;
	reg  [7:0]  ord_hi_ff;
	reg  [7:0]  size_ff;
	reg         hwen_ff;
	reg         det_ff;
	reg  [5:0]  row_s1_ff;
	reg  [5:0]  row_s2_ff;
	reg  [5:0]  row_s3_ff;
	reg  [5:0]  row_cl_ff;
	reg         tick_s1_ff;
	reg         tick_s2_ff;
	reg         tick_s3_ff;
	reg         tick_en_ff;
	reg  [15:0] div_ff;
	reg         tick_ff;
	reg  [5:0]  state_ff;
	reg  [8:0]  tcnt_ff;
	reg  [2:0]  cidx_ff;
	reg  [2:0]  ridx_ff;
	reg  [1:0]  hits_ff;
	reg  [4:0]  hcol_ff;
	reg  [5:0]  hrow_ff;
	reg         allhigh_ff;
	wire        apb_wr;
	wire        apb_rd;
	wire [9:0]  widx;
	wire        hit_map;
	wire [5:0]  row_mask;
	wire        any_low;
	wire [2:0]  ncols;
	wire [2:0]  nrows;
	wire [2:0]  cur_col;
	wire        set_det;
	wire        ctrl_rd;

	// ==================================================================
	// functions
	function [8:0] db_ticks;
		input [5:0] v;
		begin
			db_ticks = (v == 6'h00) ? 9'd256 : {1'b0, v, 2'b00};
		end
	endfunction

	function [2:0] order_at;
		input [2:0] i;
		input [15:0] o;
		begin
			case (i)
				3'd0:    order_at = o[2:0];
				3'd1:    order_at = o[6:4];
				3'd2:    order_at = o[10:8];
				3'd3:    order_at = o[14:12];
				default: order_at = o[14:12] + 3'd1;
			endcase
		end
	endfunction

	function [2:0] clamp;
		input [2:0] v;
		input [2:0] mx;
		begin
			clamp = (v == 3'd0 || v > mx) ? mx : v;
		end
	endfunction

	function [4:0] col_drive;
		input [2:0] c;
		begin
			col_drive = ~(5'h01 << c);
		end
	endfunction

	function [5:0] row_drive;
		input [2:0] r;
		begin
			row_drive = ~(6'h01 << r);
		end
	endfunction

	function [8:0] scan_ticks;
		input [1:0] s;
		begin
			scan_ticks = {7'd0, s} + 9'd1;
		end
	endfunction

	// ==================================================================
	// apb slave: zero wait states, unmapped reads zero, error on unmapped
	assign widx        = PADDR_IN[11:2];
	assign hit_map     = (widx >= W_COL) && (widx <= W_SIZE);
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit_map;
	assign apb_wr      = PSEL_IN & PENABLE_IN & PWRITE_IN & hit_map;
	assign apb_rd      = PSEL_IN & PENABLE_IN & ~PWRITE_IN & hit_map;
	assign ctrl_rd     = apb_rd & (widx == W_CTRL);
	assign KEY_IRQ_OUT = det_ff;

	// read data is combinational, which is what keeps the bus free of wait states
	always @* begin
		PRDATA_OUT = 32'h0000_0000;
		if (PSEL_IN & ~PWRITE_IN) begin
			case (widx)
				W_COL:    PRDATA_OUT = {27'h0, col_ff};
				W_ROW:    PRDATA_OUT = {26'h0, row_ff};
				W_SCAN:   PRDATA_OUT = {24'h0, scan_ff};
				W_CTRL:   PRDATA_OUT = {28'h0, tick_en_ff, hwen_ff, det_ff, 1'b0};
				W_ORD_LO: PRDATA_OUT = {24'h0, ord_lo_ff};
				W_ORD_HI: PRDATA_OUT = {24'h0, ord_hi_ff};
				W_SIZE:   PRDATA_OUT = {24'h0, size_ff};
				default:                    PRDATA_OUT = 32'h0000_0000;
			endcase
		end
	end

	// ==================================================================
	// input synchronisers: change counts once stages two and three agree
	// only the second stage reads the first, so a metastable value stays contained
	always @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			row_s1_ff  <= 6'h3f;
			row_s2_ff  <= 6'h3f;
			row_s3_ff  <= 6'h3f;
			row_cl_ff  <= 6'h3f;
			tick_s1_ff <= 1'b0;
			tick_s2_ff <= 1'b0;
			tick_s3_ff <= 1'b0;
			tick_en_ff <= 1'b0;
		end else begin
			row_s1_ff  <= ROW_IN;
			row_s2_ff  <= row_s1_ff;
			row_s3_ff  <= row_s2_ff;
			row_cl_ff  <= (row_s2_ff & row_s3_ff) | (row_cl_ff & (row_s2_ff | row_s3_ff));
			tick_s1_ff <= TICK_ENABLE_IN;
			tick_s2_ff <= tick_s1_ff;
			tick_s3_ff <= tick_s2_ff;
			if (tick_s2_ff == tick_s3_ff)
				tick_en_ff <= tick_s2_ff;
		end
	end

	// ==================================================================
	// 1 kHz tick divider; held while the enable is low so counts freeze
	always @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (tick_en_ff) begin
				if (div_ff == TICK_CYC[15:0] - 16'h0001) begin
					div_ff  <= 16'h0000;
					tick_ff <= 1'b1;
				end else begin
					div_ff <= div_ff + 16'h0001;
				end
			end
		end
	end

	// ==================================================================
	// keypad geometry; size low nibble = columns, high nibble = rows
	assign ncols    = clamp(size_ff[2:0], 3'd5);
	assign nrows    = clamp(size_ff[6:4], 3'd6);
	assign row_mask = ~(6'h3f << nrows);
	assign any_low  = |(~row_cl_ff & row_mask);
	// the fifth column is implied as the fourth entry plus one
	assign cur_col  = order_at(cidx_ff, {ord_hi_ff, ord_lo_ff});

	// bypass detect: row falls after all rows were high, no tick needed
	assign set_det = (state_ff == S_OFF) && allhigh_ff && (row_cl_ff != 6'h3f);

	// ==================================================================
	// registers and scan engine
	always @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			col_ff     <= `KMS_RST_COL;
			row_ff     <= `KMS_RST_ROW;
			scan_ff    <= `KMS_RST_SCAN;
			ord_lo_ff  <= `KMS_RST_ORDER_LO;
			ord_hi_ff  <= `KMS_RST_ORDER_HI;
			size_ff    <= `KMS_RST_SIZE;
			hwen_ff    <= 1'b0;
			det_ff     <= 1'b0;
			state_ff   <= S_OFF;
			tcnt_ff    <= 9'd0;
			cidx_ff    <= 3'd0;
			ridx_ff    <= 3'd0;
			hits_ff    <= 2'd0;
			hcol_ff    <= 5'h1f;
			hrow_ff    <= 6'h3f;
			allhigh_ff <= 1'b1;
			COL_N_OUT  <= `KMS_RST_COL;
		end else begin
			allhigh_ff <= (row_cl_ff == 6'h3f);
			// read clears the flag, but a same-cycle set wins
			if (ctrl_rd)
				det_ff <= 1'b0;
			if (apb_wr) begin
				case (widx)
					W_COL:    col_ff    <= PWDATA_IN[4:0];
					W_SCAN:   scan_ff   <= PWDATA_IN[7:0];
					W_CTRL:   hwen_ff   <= PWDATA_IN[`KMS_CTRL_HWEN];
					W_ORD_LO: ord_lo_ff <= PWDATA_IN[7:0];
					W_ORD_HI: ord_hi_ff <= PWDATA_IN[7:0];
					W_SIZE:   size_ff   <= PWDATA_IN[7:0];
					default:                    size_ff   <= size_ff;
				endcase
			end
			if (state_ff == S_OFF)
				row_ff <= row_cl_ff;
			if (set_det)
				det_ff <= 1'b1;
			if (tick_ff && tcnt_ff != 9'd0)
				tcnt_ff <= tcnt_ff - 9'd1;

			case (state_ff)
				S_OFF: begin
					COL_N_OUT <= col_ff;
					if (hwen_ff)
						state_ff <= S_IDLE;
				end
				S_IDLE: begin
					COL_N_OUT <= 5'h00;
					if (any_low) begin
						tcnt_ff  <= db_ticks(scan_ff[`KMS_SCAN_DB_HI:`KMS_SCAN_DB_LO]);
						state_ff <= S_DBPRS;
					end
				end
				S_DBPRS: begin
					if (tcnt_ff == 9'd0) begin
						if (any_low) begin
							cidx_ff  <= 3'd0;
							ridx_ff  <= 3'd0;
							hits_ff  <= 2'd0;
							tcnt_ff  <= scan_ticks(scan_ff[`KMS_SCAN_SC_HI:`KMS_SCAN_SC_LO]);
							state_ff <= S_SCAN;
						end else begin
							state_ff <= S_IDLE;
						end
					end
				end
				S_SCAN: begin
					COL_N_OUT <= col_drive(cur_col);
					// each row check waits one scan interval, whatever the order
					if (tcnt_ff == 9'd0) begin
						tcnt_ff <= scan_ticks(scan_ff[`KMS_SCAN_SC_HI:`KMS_SCAN_SC_LO]);
						if (~row_cl_ff[ridx_ff]) begin
							if (hits_ff != 2'd2)
								hits_ff <= hits_ff + 2'd1;
							hcol_ff <= col_drive(cur_col);
							hrow_ff <= row_drive(ridx_ff);
						end
						if (ridx_ff == nrows - 3'd1) begin
							ridx_ff <= 3'd0;
							if (cidx_ff == ncols - 3'd1) begin
								state_ff <= S_WREL;
								// hits_ff lags one check, so the final check is folded in here
								if (hits_ff == 2'd0 && ~row_cl_ff[ridx_ff]) begin
									col_ff <= col_drive(cur_col);
									row_ff <= row_drive(ridx_ff);
									det_ff <= 1'b1;
								end else if (hits_ff == 2'd1 && row_cl_ff[ridx_ff]) begin
									col_ff <= hcol_ff;
									row_ff <= hrow_ff;
									det_ff <= 1'b1;
								end
							end else begin
								cidx_ff <= cidx_ff + 3'd1;
							end
						end else begin
							ridx_ff <= ridx_ff + 3'd1;
						end
					end
				end
				S_WREL: begin
					COL_N_OUT <= 5'h00;
					if (~any_low) begin
						tcnt_ff  <= db_ticks(scan_ff[`KMS_SCAN_DB_HI:`KMS_SCAN_DB_LO]);
						state_ff <= S_DBREL;
					end
				end
				S_DBREL: begin
					// a bounce back to low restarts the release debounce
					if (any_low)
						tcnt_ff <= db_ticks(scan_ff[`KMS_SCAN_DB_HI:`KMS_SCAN_DB_LO]);
					else if (tcnt_ff == 9'd0)
						state_ff <= S_IDLE;
				end
				default: state_ff <= S_OFF;
			endcase
			// clearing the enable overrides any move; pins then show the column register
			if (!hwen_ff && state_ff != S_OFF)
				state_ff <= S_OFF;
		end
	end

endmodule
`default_nettype wire

// *** design/kms_map.vh ***
// register map, field positions, reset values and timing counts of the keypad scanner
`ifndef KMS_MAP_VH
`define KMS_MAP_VH
// ======================================================================
// register indices (byte address is four times the index)
`define KMS_IDX_COL        8'hd1
`define KMS_IDX_ROW        8'hd2
`define KMS_IDX_SCAN       8'hd3
`define KMS_IDX_CTRL       8'hd4
`define KMS_IDX_ORDER_LO   8'hd5
`define KMS_IDX_ORDER_HI   8'hd6
`define KMS_IDX_SIZE       8'hd7
// ======================================================================
// reset values
`define KMS_RST_COL        5'h1f
`define KMS_RST_ROW        6'h3f
`define KMS_RST_SCAN       8'h00
`define KMS_RST_ORDER_LO   8'h10
`define KMS_RST_ORDER_HI   8'h32
`define KMS_RST_SIZE       8'h56
// ======================================================================
// field positions
`define KMS_SCAN_DB_HI     7
`define KMS_SCAN_DB_LO     2
`define KMS_SCAN_SC_HI     1
`define KMS_SCAN_SC_LO     0
`define KMS_CTRL_TICK      3
`define KMS_CTRL_HWEN      2
`define KMS_CTRL_DET       1
// ======================================================================
// timing
`define KMS_CLK_HZ         50000000
`define KMS_TICK_HZ        1000
`define KMS_TICK_CYC       (`KMS_CLK_HZ / `KMS_TICK_HZ)
`define KMS_DB_STEP_MS     4
`define KMS_DB_ZERO_MS     256
`endif

// *** testbench/kms_scan_monitor.sv ***
// port assertions for the keypad scanner
`timescale 1ns/1ps
`default_nettype none
module kms_scan_monitor (
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_IN,
	input wire logic        TICK_ENABLE_IN,
	input wire logic [5:0]  ROW_IN,
	input wire logic [4:0]  COL_N_OUT,
	input wire logic        KEY_IRQ_OUT,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PSLVERR_OUT
);
	// ======================================================================
	// scan enable shadow, rebuilt from bus writes
	logic hwen_ff;
	wire  acc = PSEL_IN && PENABLE_IN;
	wire  rd_ctrl = acc && !PWRITE_IN && PADDR_IN == 12'h350;
	wire  rd_row = acc && !PWRITE_IN && PADDR_IN == 12'h348;
	wire  hit = PADDR_IN[11:2] >= 10'hd1 && PADDR_IN[11:2] <= 10'hd7;
	always @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			hwen_ff <= 1'b0;
		else if (acc && PWRITE_IN && PADDR_IN == 12'h350)
			hwen_ff <= PWDATA_IN[2];
	end
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	// ======================================================================
	// checks
	chk_err_map: assert property (acc |-> PSLVERR_OUT == !hit)
		else $error("slave error wrong");
	chk_read_clear: assert property (rd_ctrl && KEY_IRQ_OUT |=> !KEY_IRQ_OUT)
		else $error("detect not cleared");
	chk_irq_hold: assert property (KEY_IRQ_OUT && !rd_ctrl |=> KEY_IRQ_OUT)
		else $error("detect dropped");
	chk_bypass_col: assert property (acc && PWRITE_IN && PADDR_IN == 12'h344 && !hwen_ff
		|=> ##1 COL_N_OUT == $past(PWDATA_IN[4:0], 2)) else $error("column pins differ");
	chk_hw_cols: assert property (hwen_ff && $past(hwen_ff, 3)
		|-> COL_N_OUT == 5'h00 || $onehot(~COL_N_OUT)) else $error("column drive bad");
	chk_row_follow: assert property (($stable(ROW_IN) && !hwen_ff)[*8] ##0 rd_row
		|-> PRDATA_OUT[5:0] == ROW_IN) else $error("row value differs");
	chk_fall_irq: assert property (!hwen_ff && $past(ROW_IN) == 6'h3f && ROW_IN != 6'h3f
		|-> ##[1:8] KEY_IRQ_OUT) else $error("no detect on fall");
	chk_tick_freeze: assert property ((hwen_ff && !TICK_ENABLE_IN)[*8] |=> $stable(COL_N_OUT))
		else $error("scan ran without tick");
endmodule
bind kms_keypad_scanner kms_scan_monitor u_mon (.*);
`default_nettype wire

// *** testbench/kms_keypad_model.sv ***
// switch matrix: closed keys join columns to pulled-up rows
`timescale 1ns/1ps
`default_nettype none
module kms_keypad_model (
	input  wire logic [4:0]  col_n_in,
	input  wire logic [29:0] keys_in,
	output var  logic [5:0]  row_out
);
	always_comb begin
		row_out = 6'h3f;
		for (int c = 0; c < 5; c++)
			for (int r = 0; r < 6; r++)
				if (keys_in[c * 6 + r] && !col_n_in[c])
					row_out[r] = 1'b0;
	end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the keypad scanner
`timescale 1ns/1ps
`default_nettype none
`include "kms_map.vh"
module testbench;
	logic        clk = 0;
	logic        rst = 1;
	logic        ten = 1;
	logic        psel = 0;
	logic        pen = 0;
	logic        pwr = 0;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0;
	logic [29:0] keys = 0;
	logic [31:0] rd;
	logic        se;
	wire  [5:0]  row;
	wire  [4:0]  col_n;
	wire  [31:0] prd;
	wire         irq;
	wire         prdy;
	wire         perr;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          c, r, m_col, m_row;
	kms_keypad_scanner #(.TICK_CYC(10)) u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .TICK_ENABLE_IN(ten),
		.ROW_IN(row), .COL_N_OUT(col_n), .KEY_IRQ_OUT(irq), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
		.PSLVERR_OUT(perr));
	kms_keypad_model u_keys (.col_n_in(col_n), .keys_in(keys), .row_out(row));
	initial forever #10 clk = ~clk;
	// long waits are bounded, so a hang ends here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	// ======================================================================
	// tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		se = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] i, input logic [31:0] exp, input string m);
		apb(0, {2'b00, i, 2'b00}, 0);
		chk(rd, exp, m);
	endtask
	task automatic wait_irq(input int n, input logic exp, input string m);
		for (int k = 0; k < n && irq !== 1'b1; k++)
			@(posedge clk);
		chk(irq, exp, m);
	endtask
	// ======================================================================
	// main sequence
	initial begin
		void'($urandom(32'h940f));
		repeat (8) @(posedge clk);
		rst <= 0;
		rdchk(`KMS_IDX_COL, 32'h1f, "col rst");
		rdchk(`KMS_IDX_ROW, 32'h3f, "row rst");
		rdchk(`KMS_IDX_SCAN, 32'h0, "scan rst");
		rdchk(`KMS_IDX_CTRL, 32'h8, "ctrl rst");
		rdchk(8'hd8, 32'h0, "unmapped");
		chk(se, 1'b1, "slverr");
		m_row = $urandom_range(255, 0);
		apb(1, 12'h34c, m_row);
		rdchk(`KMS_IDX_SCAN, m_row, "scan rw");
		$display("registers end");
		// firmware scans by hand; last pass runs with the tick stopped
		for (int k = 0; k < 4; k++) begin
			c = $urandom_range(4, 0);
			r = $urandom_range(5, 0);
			m_col = 5'h1f ^ (1 << c);
			ten <= (k != 3);
			apb(1, 12'h344, m_col);
			repeat (2) @(posedge clk);
			chk(col_n, m_col, "bypass col");
			keys <= 30'h1 << (c * 6 + r);
			repeat (8) @(posedge clk);
			chk(irq, 1'b1, "bypass irq");
			rdchk(`KMS_IDX_ROW, 6'h3f ^ (1 << r), "bypass row");
			rdchk(`KMS_IDX_CTRL, (k != 3) ? 32'h0a : 32'h02, "det read");
			rdchk(`KMS_IDX_CTRL, (k != 3) ? 32'h08 : 32'h00, "det clr");
			keys <= 0;
			repeat (8) @(posedge clk);
		end
		$display("bypass end");
		ten <= 1;
		rdchk(`KMS_IDX_SIZE, `KMS_RST_SIZE, "size rst");
		apb(1, 12'h35c, 32'h65);
		rdchk(`KMS_IDX_SIZE, 32'h65, "size rw");
		apb(1, 12'h34c, 32'h04);
		apb(1, 12'h350, 32'h04);
		repeat (4) @(posedge clk);
		chk(col_n, 5'h00, "idle cols");
		// last pass holds two keys, which must leave the stored key alone
		for (int k = 0; k < 4; k++) begin
			c = $urandom_range(4, 0);
			r = $urandom_range(5, 0);
			if (k < 3) begin
				m_col = 5'h1f ^ (1 << c);
				m_row = 6'h3f ^ (1 << r);
			end
			keys <= (30'h1 << (c * 6 + r)) | ((k == 3) ? 30'h1 << ((c + 1) % 5 * 6 + r) : 30'h0);
			wait_irq(1500, k < 3, "hw irq");
			rdchk(`KMS_IDX_COL, m_col, "hw col");
			rdchk(`KMS_IDX_ROW, m_row, "hw row");
			rdchk(`KMS_IDX_CTRL, (k < 3) ? 32'h0e : 32'h0c, "hw stat");
			if (k == 0) begin
				apb(1, 12'h354, 32'h04);
				apb(1, 12'h358, 32'h21);
				rdchk(`KMS_IDX_ORDER_LO, 32'h04, "order lo");
			end
			keys <= 0;
			repeat (150) @(posedge clk);
			chk(col_n, 5'h00, "release cols");
		end
		ten <= 0;
		keys <= 30'h1;
		repeat (300) @(posedge clk);
		chk(irq, 1'b0, "frozen");
		ten <= 1;
		wait_irq(1500, 1'b1, "thawed");
		rdchk(`KMS_IDX_COL, 32'h1e, "col0");
		rdchk(`KMS_IDX_ROW, 32'h3e, "row0");
		apb(1, 12'h350, 0);
		repeat (3) @(posedge clk);
		chk(col_n, 5'h1e, "off cols");
		$display("scan end");
		test_done();
	end
endmodule
`default_nettype wire
